// ===== design/clbu_pkg.sv
// Package with encodings and widths for the count-leading-bits unit
package clbu_pkg;
	localparam int           DATA_W          = 64;             // General register width
	localparam int           WORD_W          = 32;             // Scanned word width
	localparam int           CNT_W           = 6;              // Count 0..32
	localparam logic [5:0]   OP_LEGACY       = 6'h1c;          // legacy_extended_major_opcode
	localparam logic [5:0]   OP_NEWER        = 6'h00;          // Newer major opcode
	localparam logic [5:0]   FN_LEG_ONES     = 6'h21;          // Legacy count_leading_ones
	localparam logic [5:0]   FN_LEG_ZEROS    = 6'h20;          // Legacy count_leading_zeros
	localparam logic [5:0]   FN_NEW_ONES     = 6'h11;          // Newer count_leading_ones
	localparam logic [5:0]   FN_NEW_ZEROS    = 6'h10;          // Newer count_leading_zeros
	localparam logic [4:0]   SA_LEGACY       = 5'h00;          // Bits 10..6, legacy form
	localparam logic [4:0]   SA_NEWER        = 5'h01;          // Bits 10..6, newer form
	localparam logic [4:0]   SECOND_SRC_ZERO = 5'h00;          // second_source_field, newer form
	localparam int           OP_HI           = 31;             // Major opcode position
	localparam int           SRC_HI          = 25;             // source_field position
	localparam int           SEC_HI          = 20;             // second_source_field position
	localparam int           DST_HI          = 15;             // Destination field position
	localparam int           SA_HI           = 10;             // Bits 10..6
	localparam int           FN_HI           = 5;              // Function field
	localparam logic [63:0]  RESULT_RST      = 64'h0;          // Result reset value
	// Kind of decoded operation
	typedef enum logic [1:0] {CLBU_NONE, CLBU_ONES, CLBU_ZEROS} clbu_op_e;
endpackage

// ===== design/clbu_if.sv
// Interface between the decode and counter sections of the unit
`timescale 1ns/1ps
interface clbu_if;
	logic [31:0] word;   // Word to scan (already inverted for ones)
	logic [5:0]  count;  // Leading zero count of word
	modport ctl (output word, input count);
	modport cnt (input word, output count);
endinterface

// ===== design/clbu_counter.sv
// Leading-zero counter over a 32-bit word
`timescale 1ns/1ps
module clbu_counter (
	clbu_if.cnt bus
);
	// Scan from bit 0 up; the last one found, the highest set bit, sets the count
	always_comb begin
		bus.count = 6'h20;                                 // All zero gives 32
		for (int i = 0; i < 32; i++) begin
			if (bus.word[i]) begin
				bus.count = 6'(31 - i);                    // Lowest loop index overwritten by higher
			end
		end
	end
endmodule

// ===== design/clbu_unit.sv
// Count-leading-bits unit: decode, scan and registered write-back
// Behaviour
// - decode leading-ones in legacy and newer encodings
// - decode leading-zeros in legacy and newer encodings
// - count leading ones from bit 31 down
// - all ones gives thirty-two
// - count leading zeros from bit 31 down
// - all zeros gives thirty-two
// - defined only for sign-extended word operands
// - newer form needs second source zero
`timescale 1ns/1ps
module clbu_unit (
	input  wire logic        clk_sys,      // System clock, 25 MHz
	input  wire logic        sys_rst,      // Synchronous reset, active high
	input  wire logic        issue_valid,  // Instruction presented this cycle
	input  wire logic [31:0] instr,        // Instruction word from decode
	input  wire logic [63:0] src_data,     // general_register read of source_field
	output logic             wb_valid,     // Write-back strobe, one cycle
	output logic [4:0]       wb_dest,      // Destination register number
	output logic [63:0]      wb_data,      // Count, zero-extended
	output logic             op_hit,       // Registered: instruction was ours
	output logic             exc_raise     // Exception request, always low
);
	clbu_if cbus ();                        // Path to the counter
	clbu_pkg::clbu_op_e op_kind;            // Decoded operation
	logic [5:0]  f_op;                      // Major opcode field
	logic [4:0]  f_sec;                     // second_source_field
	logic [4:0]  f_dst;                     // Destination field
	logic [4:0]  f_sa;                      // Bits 10..6
	logic [5:0]  f_fn;                      // Function field
	logic        wb_valid_r, wb_valid_nxt;  // Write-back strobe state
	logic [4:0]  wb_dest_r, wb_dest_nxt;    // Destination state
	logic [63:0] wb_data_r, wb_data_nxt;    // Result state
	logic        hit_r, hit_nxt;            // Hit flag state
	logic        exc_r, exc_nxt;            // Exception request state, held low

	// One shared counter; the ones case feeds it the inverted word, which
	// costs one row of inverters and saves a second priority scanner
	clbu_counter u_cnt (
		.bus(cbus)
	);

	// Field slicing; all six fields sit at fixed places in both encodings:
	// 31..26 major opcode, 25..21 source_field, 20..16 second_source_field,
	// 15..11 destination, 10..6 sub-code, 5..0 function.
	// source_field itself is not needed here: the register file has already
	// read it and hands its value over on src_data.
	assign f_op  = instr[clbu_pkg::OP_HI -: 6];
	assign f_sec = instr[clbu_pkg::SEC_HI -: 5];
	assign f_dst = instr[clbu_pkg::DST_HI -: 5];
	assign f_sa  = instr[clbu_pkg::SA_HI -: 5];
	assign f_fn  = instr[clbu_pkg::FN_HI -: 6];

	// Anything that matches neither encoding leaves op_kind at none, so the
	// unit stays silent and another execution unit may own the word.
	// A legacy word with a nonzero sub-code, or a newer word with a nonzero
	// second_source_field, is refused the same way.
	// Decode both encodings; legacy form ignores second_source_field, the
	// producer must make it equal the destination
	always_comb begin
		op_kind = clbu_pkg::CLBU_NONE;
		if (f_op == clbu_pkg::OP_LEGACY && f_sa == clbu_pkg::SA_LEGACY) begin
			if (f_fn == clbu_pkg::FN_LEG_ONES) begin
				op_kind = clbu_pkg::CLBU_ONES;
			end else if (f_fn == clbu_pkg::FN_LEG_ZEROS) begin
				op_kind = clbu_pkg::CLBU_ZEROS;
			end
		end else if (f_op == clbu_pkg::OP_NEWER && f_sa == clbu_pkg::SA_NEWER
				&& f_sec == clbu_pkg::SECOND_SRC_ZERO) begin
			if (f_fn == clbu_pkg::FN_NEW_ONES) begin
				op_kind = clbu_pkg::CLBU_ONES;
			end else if (f_fn == clbu_pkg::FN_NEW_ZEROS) begin
				op_kind = clbu_pkg::CLBU_ZEROS;
			end
		end
	end

	// Ones are counted as zeros of the inverted word, so one counter serves both.
	// Only bits 31..0 are scanned; upper bits are ignored, which is a legal
	// outcome for non-sign-extended operands
	assign cbus.word = (op_kind == clbu_pkg::CLBU_ONES) ? ~src_data[31:0]
	                                                    : src_data[31:0];

	// Next-state of the write-back stage. The result appears one edge after
	// the issue edge; destination and data then hold until the next hit, so
	// write-back may read them late without a copy of its own.
	always_comb begin
		wb_valid_nxt = 1'b0;
		exc_nxt      = 1'b0;                               // No operand can trap
		wb_dest_nxt  = wb_dest_r;
		wb_data_nxt  = wb_data_r;
		hit_nxt      = 1'b0;
		if (issue_valid && op_kind != clbu_pkg::CLBU_NONE) begin
			wb_valid_nxt = 1'b1;
			hit_nxt      = 1'b1;
			wb_dest_nxt  = f_dst;
			wb_data_nxt  = {58'h0, cbus.count};
		end
	end

	// Registers of the write-back stage
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wb_valid_r <= 1'b0;
			wb_dest_r  <= 5'h00;
			wb_data_r  <= clbu_pkg::RESULT_RST;
			hit_r      <= 1'b0;
			exc_r      <= 1'b0;
		end else begin
			wb_valid_r <= wb_valid_nxt;
			wb_dest_r  <= wb_dest_nxt;
			wb_data_r  <= wb_data_nxt;
			hit_r      <= hit_nxt;
			exc_r      <= exc_nxt;
		end
	end

	// Every output is taken straight from a flip-flop of the stage
	assign wb_valid  = wb_valid_r;
	assign wb_dest   = wb_dest_r;
	assign wb_data   = wb_data_r;
	assign op_hit    = hit_r;
	assign exc_raise = exc_r;                              // Held low

	// Checks on decode and result. Each expected count is written from the
	// rule itself, never from the counter, so a broken scan shows up here.
	// All of them are off while reset is high.
	// Legacy ones instruction yields a write one cycle later
	a_leg_ones_hit: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] == 6'h1c && instr[10:0] == 11'h021 |=> wb_valid)
		else $error("legacy ones not decoded");
	// Newer zeros needs second source zero
	a_new_zero_sec: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] == 6'h00 && instr[10:0] == 11'h050
		|=> wb_valid == ($past(instr[20:16]) == 5'h00))
		else $error("newer zeros second source check wrong");
	// Newer zeros decodes whatever source_field holds
	a_new_zero_hit: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] == 6'h00 && instr[20:16] == 5'h00
		&& instr[10:0] == 11'h050 |=> wb_valid)
		else $error("newer zeros not decoded");
	// Top nibble 1110 gives three leading ones
	a_ones_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ONES && src_data[31:28] == 4'he
		|=> wb_data == 64'h3)
		else $error("ones count wrong");
	// All ones gives 32
	a_ones_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ONES && src_data[31:0] == 32'hffffffff
		|=> wb_data == 64'h20)
		else $error("all ones not 32");
	// Zeros count with top bit clear and bit 30 set is one
	a_zeros_top: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ZEROS && src_data[31:30] == 2'h1
		|=> wb_data == 64'h1)
		else $error("zeros count wrong");
	// All zero gives 32
	a_zeros_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ZEROS && src_data[31:0] == 32'h0
		|=> wb_data == 64'h20)
		else $error("all zeros not 32");
	// Result never exceeds 32 and upper bits stay zero
	a_zero_ext: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wb_valid |-> wb_data[63:6] == 58'h0 && wb_data[5:0] <= 6'h20)
		else $error("result not zero-extended");
	// No exception ever
	a_no_exc: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!exc_raise)
		else $error("exception raised");
	// Destination follows the accepted instruction
	a_dest_track: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind != clbu_pkg::CLBU_NONE |=> wb_dest == $past(instr[15:11]))
		else $error("destination wrong");

	// Legacy zeros instruction yields a write one cycle later
	a_leg_zero_hit: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] == 6'h1c && instr[10:0] == 11'h020 |=> wb_valid)
		else $error("legacy zeros not decoded");
	// Newer ones decodes when second source is zero
	a_new_ones_hit: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] == 6'h00 && instr[20:16] == 5'h00
		&& instr[10:0] == 11'h051 |=> wb_valid)
		else $error("newer ones not decoded");
	// Legacy form with a nonzero sub-code is refused
	a_leg_sa_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] == 6'h1c && instr[10:6] != 5'h00 |=> !wb_valid)
		else $error("legacy bad sub-code accepted");
	// Newer form with another function code is refused
	a_fn_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] == 6'h00 && instr[5:1] != 5'h08 |=> !wb_valid)
		else $error("newer foreign function accepted");
	// Any other major opcode is refused
	a_op_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && instr[31:26] != 6'h1c && instr[31:26] != 6'h00
		|=> !wb_valid)
		else $error("foreign opcode accepted");
	// Hit flag and strobe move together
	a_hit_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst)
		op_hit == wb_valid)
		else $error("hit flag and strobe differ");
	// A strobe always follows an issue
	a_valid_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wb_valid |-> $past(issue_valid))
		else $error("strobe without issue");
	// Sixteen leading zeros give sixteen
	a_zeros_mid: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ZEROS && src_data[31:15] == 17'h00001
		|=> wb_data == 64'h10)
		else $error("zeros mid count wrong");
	// Lowest bit zero alone gives thirty-one ones
	a_ones_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ONES && src_data[31:0] == 32'hfffffffe
		|=> wb_data == 64'h1f)
		else $error("ones low count wrong");
	// Top bit clear gives no leading ones
	a_ones_top_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ONES && !src_data[31]
		|=> wb_data == 64'h0)
		else $error("ones top count wrong");
	// Only the lowest bit set gives thirty-one zeros
	a_zeros_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		issue_valid && op_kind == clbu_pkg::CLBU_ZEROS && src_data[31:0] == 32'h1
		|=> wb_data == 64'h1f)
		else $error("zeros low count wrong");
endmodule

// ===== sim/clbu_partner.sv
// Decode-stage model that presents instructions and source operands
`timescale 1ns/1ps
module clbu_partner (
	input  wire logic        clk_sys,      // System clock
	output logic             issue_valid,  // Instruction strobe
	output logic [31:0]      instr,        // Instruction word
	output logic [63:0]      src_data      // Source register value
);
	// Quiet bus at time zero
	initial begin
		issue_valid = 1'b0;
		instr       = 32'h0;
		src_data    = 64'h0;
	end
	// One instruction per call, changed after the falling edge
	task automatic issue(input logic [5:0] op, input logic [4:0] sec, input logic [4:0] dst,
		input logic [4:0] sa, input logic [5:0] fn, input logic [31:0] w);
		@(negedge clk_sys);
		issue_valid = 1'b1;
		// Legacy form repeats the destination number here
		if (op == clbu_pkg::OP_LEGACY) begin
			sec = dst;
		end
		instr    = {op, 5'h03, sec, dst, sa, fn};
		src_data = {{32{w[31]}}, w};
	endtask
	// Release: stale values are inverted so nothing passes by accident
	task automatic idle();
		@(negedge clk_sys);
		issue_valid = 1'b0;
		instr       = ~instr;
		src_data    = ~src_data;
	endtask
endmodule

// ===== sim/tb_count_leading_bits_unit.sv
// Self-checking bench for the count-leading-bits unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %s exp %h seen %h", nm, e, g); end end
module tb_count_leading_bits_unit;
	typedef struct {logic [5:0] op; logic [4:0] sec; logic [4:0] sa; logic [5:0] fn;
		logic [31:0] w; logic hit; logic [5:0] cnt;} clbu_row_s;  // One case
	localparam logic [5:0] lg = clbu_pkg::OP_LEGACY;  // Legacy major opcode
	localparam logic [5:0] nw = clbu_pkg::OP_NEWER;   // Newer major opcode
	logic        clk_sys;      // 25 MHz clock
	logic        sys_rst;      // Sync reset
	logic        issue_valid;  // From partner
	logic [31:0] instr;        // From partner
	logic [63:0] src_data;     // From partner
	logic        wb_valid;     // Write-back strobe
	logic [4:0]  wb_dest;      // Destination number
	logic [63:0] wb_data;      // Count result
	logic        op_hit;       // Ours flag
	logic        exc_raise;    // Exception request
	int          error_cnt;    // Mismatches
	int          n_tests;      // Comparisons
	clbu_row_s   rows [15];    // Back-to-back cases
	clbu_partner p_u (.clk_sys(clk_sys), .issue_valid(issue_valid), .instr(instr),
		.src_data(src_data));
	clbu_unit dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .issue_valid(issue_valid),
		.instr(instr), .src_data(src_data), .wb_valid(wb_valid), .wb_dest(wb_dest),
		.wb_data(wb_data), .op_hit(op_hit), .exc_raise(exc_raise));
	// Clock, 40 ns period
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Report and stop
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog, far beyond the few dozen cycles needed
	initial begin
		repeat (2000) @(posedge clk_sys);
		error_cnt++;
		give_verdict();
	end
	// Main sequence
	initial begin
		error_cnt = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		rows = '{'{lg, 5'h00, 5'h00, 6'h21, 32'hf0000000, 1'b1, 6'h04},
			'{lg, 5'h00, 5'h00, 6'h21, 32'hffffffff, 1'b1, 6'h20},
			'{lg, 5'h00, 5'h00, 6'h21, 32'h00000000, 1'b1, 6'h00},
			'{nw, 5'h00, 5'h01, 6'h11, 32'h7fffffff, 1'b1, 6'h00},
			'{nw, 5'h00, 5'h01, 6'h11, 32'hfffffffe, 1'b1, 6'h1f},
			'{lg, 5'h00, 5'h00, 6'h20, 32'h00000001, 1'b1, 6'h1f},
			'{nw, 5'h00, 5'h01, 6'h10, 32'h00000000, 1'b1, 6'h20},
			'{nw, 5'h00, 5'h01, 6'h10, 32'h80000000, 1'b1, 6'h00},
			'{nw, 5'h01, 5'h01, 6'h11, 32'h00000000, 1'b0, 6'h00},
			'{lg, 5'h00, 5'h01, 6'h20, 32'h00000000, 1'b0, 6'h00},
			'{nw, 5'h00, 5'h01, 6'h12, 32'h00000000, 1'b0, 6'h00},
			'{lg, 5'h00, 5'h00, 6'h21, 32'he0000000, 1'b1, 6'h03},
			'{nw, 5'h00, 5'h01, 6'h10, 32'h40000000, 1'b1, 6'h01},
			'{nw, 5'h01, 5'h01, 6'h10, 32'h00000000, 1'b0, 6'h00},
			'{6'h1d, 5'h00, 5'h00, 6'h21, 32'h00000000, 1'b0, 6'h00}};
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		// Table cases issued every cycle, result checked one edge later
		foreach (rows[i]) begin
			p_u.issue(rows[i].op, rows[i].sec, 5'(i + 1), rows[i].sa, rows[i].fn, rows[i].w);
			@(posedge clk_sys);
			#1;
			`CHK("wb_valid", rows[i].hit, wb_valid)
			`CHK("op_hit", rows[i].hit, op_hit)
			`CHK("exc_raise", 1'b0, exc_raise)
			if (rows[i].hit) begin
				`CHK("wb_data", {58'h0, rows[i].cnt}, wb_data)
				`CHK("wb_dest", 5'(i + 1), wb_dest)
			end
			$display("test %0d done", i);
		end
		// Reset wins over a valid issue in mid-run
		p_u.issue(lg, 5'h00, 5'h09, 5'h00, 6'h21, 32'hffffffff);
		sys_rst = 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK("rst wb_valid", 1'b0, wb_valid)
		`CHK("rst wb_data", 64'h0, wb_data)
		`CHK("rst wb_dest", 5'h00, wb_dest)
		`CHK("rst op_hit", 1'b0, op_hit)
		// First edge after release is accepted; release at the falling edge
		p_u.issue(lg, 5'h00, 5'h1f, 5'h00, 6'h20, 32'h0000ffff);
		sys_rst = 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK("post wb_valid", 1'b1, wb_valid)
		`CHK("post wb_data", 64'h10, wb_data)
		`CHK("post wb_dest", 5'h1f, wb_dest)
		p_u.idle();
		@(posedge clk_sys);
		#1;
		`CHK("idle wb_valid", 1'b0, wb_valid)
		`CHK("idle op_hit", 1'b0, op_hit)
		$display("test reset done");
		give_verdict();
	end
endmodule
